/* File: hlsc_pkg.sv */
// Package: constants, types and register map for the host link state control block.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register port.
package hlsc_pkg;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DOMAIN0 = 8'h08;
    localparam logic [7:0] REG_DOMAIN1 = 8'h0C;
    localparam logic [7:0] REG_CLKRATE = 8'h10;
    localparam logic [7:0] REG_CHANNEL = 8'h14;
    localparam logic [7:0] REG_XCVR = 8'h18;
    localparam logic [7:0] REG_RESULT = 8'h1C;

    // Status field positions
    localparam int ST_HOLDOFF = 0;
    localparam int ST_CONFIG = 1;
    localparam int ST_DOM0_VALID = 2;
    localparam int ST_DOM1_VALID = 3;
    localparam int ST_CLK_REJ = 4;
    localparam int ST_CHAN_REJ = 5;
    localparam int ST_SW = 6;

    // Reset values and fixed figures
    localparam logic [31:0] CLKRATE_HZ = 32'h0098_9680; // 10 MHz in Hz
    localparam logic [31:0] DOMAIN_RST = 32'h0000_0000;
    localparam logic [7:0] XCVR_RST = 8'h00;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // Host commands on the command port
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_HOST_RESET = 3'h1,
        CMD_HOLDOFF_CANCEL = 3'h2,
        CMD_LOCAL_MGMT = 3'h3,
        CMD_SEND = 3'h4
    } hlsc_cmd_t;

    // Host command with its payload
    typedef struct packed {
        logic valid;
        hlsc_cmd_t cmd;
        logic acked;
    } hlsc_req_t;

    // Send completion report
    typedef struct packed {
        logic valid;
        logic success;
        logic sent;
    } hlsc_cpl_t;

    // Top-level state: one-hot
    typedef enum logic [2:0] {
        ST_RESETTING = 3'b001,
        ST_HELD = 3'b010,
        ST_NORMAL = 3'b100
    } hlsc_state_t;

endpackage : hlsc_pkg

/* File: hlsc_nv_word.sv */
// Nonvolatile-style storage word: keeps its value across the block's
// soft reset; only a power-on clear (por) sets it back.
// Assumes the platform keeps por low except at true power-up.
module hlsc_nv_word #(
    parameter int W = 32,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_sys,
    input wire logic por,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    output logic [W-1:0] value
);

    logic [W-1:0] val_q;

    // Survives soft reset, cleared only at power-on
    always_ff @(posedge clk_sys or posedge por)
    begin
        if (por)
            val_q <= INIT;
        else if (wr_en)
            val_q <= wr_data;
    end

    assign value = val_q;

endmodule : hlsc_nv_word

/* File: hlsc_top.sv */
// Host link state control: hold-off, configuration and send completion logic
// with an AXI4-Lite register port.
// Assumes rst is the block reset and por the power-on reset; both are
// asynchronous and active high; all other inputs are synchronous to clk_sys.
module hlsc_top #(
    parameter logic [7:0] XCVR_ID = 8'h01
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic por,
    input wire logic net_enable_switch,
    // Host command port
    input wire hlsc_pkg::hlsc_req_t host_req,
    output hlsc_pkg::hlsc_cpl_t send_cpl,
    output logic uplink_host_reset,
    output logic local_mgmt_exec,
    // Network side
    input wire logic net_mgmt_in,
    input wire logic net_app_in,
    output logic net_mgmt_answer,
    output logic net_app_answer,
    output logic net_tx,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    hlsc_pkg::hlsc_state_t state_q;
    hlsc_pkg::hlsc_state_t state_d;
    logic soft_rst_q;
    logic clk_rej_q;
    logic chan_rej_q;
    logic [31:0] clkrate_q;
    logic [7:0] chan_q;
    logic [31:0] dom0_val;
    logic [31:0] dom1_val;
    logic [2:0] cfg_val;
    hlsc_pkg::hlsc_cpl_t send_cpl_q;
    logic uplink_rst_q;
    logic local_mgmt_q;
    logic net_mgmt_ans_q;
    logic net_app_ans_q;
    logic net_tx_q;

    // AXI write and read channel holding registers
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Write decode
    wire aw_take = s_axi_awvalid && !aw_have_q && !bvalid_q;
    wire w_take = s_axi_wvalid && !w_have_q && !bvalid_q;
    wire wr_fire = aw_have_q && w_have_q && !bvalid_q;
    wire full_word = (w_strb_q == 4'hF);
    wire wr_ctrl = wr_fire && aw_addr_q == hlsc_pkg::REG_CTRL;
    wire wr_dom0 = wr_fire && aw_addr_q == hlsc_pkg::REG_DOMAIN0 && full_word;
    wire wr_dom1 = wr_fire && aw_addr_q == hlsc_pkg::REG_DOMAIN1 && full_word;
    wire wr_clk = wr_fire && aw_addr_q == hlsc_pkg::REG_CLKRATE && full_word;
    wire wr_chan = wr_fire && aw_addr_q == hlsc_pkg::REG_CHANNEL && w_strb_q[0];
    wire wr_known = wr_fire && (aw_addr_q == hlsc_pkg::REG_CTRL
        || aw_addr_q == hlsc_pkg::REG_DOMAIN0 || aw_addr_q == hlsc_pkg::REG_DOMAIN1
        || aw_addr_q == hlsc_pkg::REG_CLKRATE || aw_addr_q == hlsc_pkg::REG_CHANNEL);

    // Domain assignment, configure request and clear; reject rules
    wire clk_ok = (w_data_q == hlsc_pkg::CLKRATE_HZ);
    wire chan_ok = (w_data_q[7:0] == XCVR_ID);
    wire dom0_valid = cfg_val[1];
    wire dom1_valid = cfg_val[2];
    wire cfg_req = wr_ctrl && w_strb_q[0] && w_data_q[0];
    wire uncfg_req = wr_ctrl && w_strb_q[0] && w_data_q[1];
    wire cfg_allowed = dom0_valid || dom1_valid;
    wire configured = cfg_val[0];
    logic [2:0] cfg_next;

    // Configuration word: bit0 configured, bit1/2 domain valid
    always_comb
    begin
        cfg_next = cfg_val;
        if (wr_dom0)
            cfg_next[1] = 1'b1;
        if (wr_dom1)
            cfg_next[2] = 1'b1;
        if (cfg_req && cfg_allowed)
            cfg_next[0] = 1'b1;
        if (uncfg_req)
            cfg_next = 3'h0;
    end

    // Nonvolatile configuration and domain words
    hlsc_nv_word #(.W(3), .INIT(3'h0)) u_nv_cfg (
        .clk_sys(clk_sys),
        .por(por),
        .wr_en(wr_dom0 || wr_dom1 || cfg_req || uncfg_req),
        .wr_data(cfg_next),
        .value(cfg_val)
    );
    hlsc_nv_word #(.W(32), .INIT(hlsc_pkg::DOMAIN_RST)) u_nv_dom0 (
        .clk_sys(clk_sys),
        .por(por),
        .wr_en(wr_dom0),
        .wr_data(w_data_q),
        .value(dom0_val)
    );
    hlsc_nv_word #(.W(32), .INIT(hlsc_pkg::DOMAIN_RST)) u_nv_dom1 (
        .clk_sys(clk_sys),
        .por(por),
        .wr_en(wr_dom1),
        .wr_data(w_data_q),
        .value(dom1_val)
    );

    // Command decode
    wire is_reset_cmd = host_req.valid && host_req.cmd == hlsc_pkg::CMD_HOST_RESET;
    wire is_cancel = host_req.valid && host_req.cmd == hlsc_pkg::CMD_HOLDOFF_CANCEL;
    wire is_mgmt = host_req.valid && host_req.cmd == hlsc_pkg::CMD_LOCAL_MGMT;
    wire is_send = host_req.valid && host_req.cmd == hlsc_pkg::CMD_SEND;
    wire held = (state_q == hlsc_pkg::ST_HELD);
    wire normal = (state_q == hlsc_pkg::ST_NORMAL);

    // State machine: reset phase, hold-off, normal
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            hlsc_pkg::ST_RESETTING:
                state_d = net_enable_switch ? hlsc_pkg::ST_NORMAL
                                            : hlsc_pkg::ST_HELD;
            hlsc_pkg::ST_HELD:
                if (is_cancel)
                    state_d = hlsc_pkg::ST_NORMAL;
            hlsc_pkg::ST_NORMAL:
                state_d = hlsc_pkg::ST_NORMAL;
            default:
                state_d = hlsc_pkg::ST_RESETTING;
        endcase
        if (is_reset_cmd)
            state_d = hlsc_pkg::ST_RESETTING;
    end

    // State register; reset enters the reset phase
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            state_q <= hlsc_pkg::ST_RESETTING;
        else
            state_q <= state_d;
    end

    // Marks a fresh reset phase so the uplink reset message goes first
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            soft_rst_q <= 1'b1;
        else
            soft_rst_q <= is_reset_cmd;
    end

    // Uplink reset notice, one pulse as the reset phase ends
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            uplink_rst_q <= 1'b0;
        else
            uplink_rst_q <= soft_rst_q;
    end

    // Send completion: hold-off and unconfigured outcomes
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            send_cpl_q <= '0;
            net_tx_q <= 1'b0;
        end
        else
        begin
            send_cpl_q.valid <= is_send && !soft_rst_q && state_q != hlsc_pkg::ST_RESETTING;
            if (is_send && !soft_rst_q) // Outcome kept until the next send
            begin
                send_cpl_q.success <= held ? !host_req.acked : 1'b1;
                send_cpl_q.sent <= normal && configured;
            end
            net_tx_q <= is_send && normal && configured;
        end
    end

    // Local management still runs during hold-off
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            local_mgmt_q <= 1'b0;
        else
            local_mgmt_q <= is_mgmt && (held || normal);
    end

    // Network answers gated by hold-off; application answers also by configuration
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            net_mgmt_ans_q <= 1'b0;
            net_app_ans_q <= 1'b0;
        end
        else
        begin
            net_mgmt_ans_q <= net_mgmt_in && normal;
            net_app_ans_q <= net_app_in && normal && configured;
        end
    end

    // Hardware property and channel updates with rejection
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            clkrate_q <= hlsc_pkg::CLKRATE_HZ;
            chan_q <= hlsc_pkg::XCVR_RST;
            clk_rej_q <= 1'b0;
            chan_rej_q <= 1'b0;
        end
        else
        begin
            if (wr_clk)
            begin
                clk_rej_q <= !clk_ok;
                if (clk_ok)
                    clkrate_q <= w_data_q;
            end
            if (wr_chan)
            begin
                chan_rej_q <= !chan_ok;
                if (chan_ok)
                    chan_q <= w_data_q[7:0];
            end
        end
    end

    // AXI write address/data capture and response
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= hlsc_pkg::AXI_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_known ? hlsc_pkg::AXI_OKAY : hlsc_pkg::AXI_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // Read data selection
    wire [31:0] status_word = {25'h0, net_enable_switch, chan_rej_q, clk_rej_q,
        dom1_valid, dom0_valid, configured, held};
    wire rd_known = s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[1:0] == 2'h0;
    logic [31:0] rd_mux;

    always_comb
    begin
        unique case (s_axi_araddr)
            hlsc_pkg::REG_CTRL: rd_mux = {31'h0, configured};
            hlsc_pkg::REG_STATUS: rd_mux = status_word;
            hlsc_pkg::REG_DOMAIN0: rd_mux = dom0_val;
            hlsc_pkg::REG_DOMAIN1: rd_mux = dom1_val;
            hlsc_pkg::REG_CLKRATE: rd_mux = clkrate_q;
            hlsc_pkg::REG_CHANNEL: rd_mux = {24'h0, chan_q};
            hlsc_pkg::REG_XCVR: rd_mux = {24'h0, XCVR_ID};
            hlsc_pkg::REG_RESULT: rd_mux = {31'h0, send_cpl_q.success};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // AXI read: address taken when no read is outstanding
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= hlsc_pkg::AXI_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_known ? hlsc_pkg::AXI_OKAY : hlsc_pkg::AXI_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // Outputs from flip-flops; the AXI ready signals are decoded from flip-flops
    assign send_cpl = send_cpl_q;
    assign uplink_host_reset = uplink_rst_q;
    assign local_mgmt_exec = local_mgmt_q;
    assign net_mgmt_answer = net_mgmt_ans_q;
    assign net_app_answer = net_app_ans_q;
    assign net_tx = net_tx_q;
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule : hlsc_top

/* File: hlsc_chk.sv */
// Checker for the host link state control block: resets, hold-off and send completions.
// Assumes it is bound into hlsc_top; one clock, rst asynchronous and active high.
module hlsc_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic net_enable_switch,
    input wire hlsc_pkg::hlsc_req_t host_req,
    input wire hlsc_pkg::hlsc_cpl_t send_cpl,
    input wire logic uplink_host_reset,
    input wire logic local_mgmt_exec,
    input wire logic net_mgmt_in,
    input wire logic net_mgmt_answer,
    input wire logic net_tx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rs_q;
    logic held_q;

    // Decoded host commands
    wire logic send_w = host_req.valid && host_req.cmd == hlsc_pkg::CMD_SEND;
    wire logic rst_cmd_w = host_req.valid && host_req.cmd == hlsc_pkg::CMD_HOST_RESET;
    wire logic cancel_w = host_req.valid && host_req.cmd == hlsc_pkg::CMD_HOLDOFF_CANCEL;
    wire logic mgmt_w = host_req.valid && host_req.cmd == hlsc_pkg::CMD_LOCAL_MGMT;

    // Shadow of the resetting and hold-off states, rebuilt from the ports
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            {rs_q, held_q} <= 2'b11;
        else
        begin
            rs_q <= rst_cmd_w;
            held_q <= rs_q ? !net_enable_switch : held_q && !cancel_w;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Multi-step behaviours
    sequence reset_cmd_s;
        rst_cmd_w ##1 rs_q;
    endsequence
    sequence held_send_s;
        send_w && held_q && !rs_q;
    endsequence

    // Checks at the ports
    send_src_a: assert property (send_cpl.valid |-> $past(send_w))
        else $error("send completion without a send request");
    tx_ok_a: assert property (net_tx |-> send_cpl.valid && send_cpl.sent && send_cpl.success)
        else $error("transmit without a successful completion");
    rst_uplink_a: assert property ($fell(rst) |=> uplink_host_reset)
        else $error("no uplink host reset after reset release");
    cmd_uplink_a: assert property (reset_cmd_s |=> uplink_host_reset)
        else $error("no uplink host reset after host reset command");
    mgmt_block_a: assert property (net_mgmt_in && held_q && !rs_q |=> !net_mgmt_answer)
        else $error("management message answered while held off");
    mgmt_open_a: assert property (net_mgmt_in && !held_q && !rs_q |=> net_mgmt_answer)
        else $error("management message not answered after hold-off ended");
    held_send_a: assert property (held_send_s |=> send_cpl.valid && !send_cpl.sent && !net_tx
        && send_cpl.success == !$past(host_req.acked))
        else $error("wrong completion for a send while held off");
    local_mgmt_a: assert property (mgmt_w && !rs_q |=> local_mgmt_exec)
        else $error("local management command not executed");
endmodule : hlsc_chk

/* File: hlsc_host_model.sv */
// Host processor model: issues one command pulse per bench request.
// Assumes at most one request per cycle; cancels hold-off after uplink resets if asked.
module hlsc_host_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic go,
    input wire hlsc_pkg::hlsc_cmd_t go_cmd,
    input wire logic go_acked,
    input wire logic auto_cancel,
    input wire logic uplink_host_reset,
    output hlsc_pkg::hlsc_req_t host_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // One-cycle command pulse; bench commands win over the automatic cancel
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            host_req <= '0;
        else if (go)
            host_req <= '{1'b1, go_cmd, go_acked};
        else if (auto_cancel && uplink_host_reset)
            host_req <= '{1'b1, hlsc_pkg::CMD_HOLDOFF_CANCEL, 1'b0};
        else
            host_req <= '0;
    end
endmodule : hlsc_host_model

/* File: hlsc_tb_top.sv */
// Testbench for hlsc_top: hold-off, sends, configuration and parameter checks.
// Assumes the host model file and the checker are compiled alongside.
module hlsc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] HM = 32'h1 << hlsc_pkg::ST_HOLDOFF;
    localparam logic [31:0] CM = 32'h1 << hlsc_pkg::ST_CONFIG;
    localparam logic [7:0] XCVR = 8'h01; // Arbitrary transceiver code
    logic clk_sys, rst, por, net_enable_switch, go, go_acked, auto_cancel;
    logic net_mgmt_in, net_app_in, net_mgmt_answer, net_app_answer, net_tx;
    logic uplink_host_reset, local_mgmt_exec;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    hlsc_pkg::hlsc_cmd_t go_cmd;
    hlsc_pkg::hlsc_req_t host_req;
    hlsc_pkg::hlsc_cpl_t send_cpl;
    int failures = 0;
    int check_count = 0;

    // Design and host partner
    hlsc_top #(.XCVR_ID(XCVR)) dut (
        .clk_sys(clk_sys), .rst(rst), .por(por), .net_enable_switch(net_enable_switch),
        .host_req(host_req), .send_cpl(send_cpl), .uplink_host_reset(uplink_host_reset),
        .local_mgmt_exec(local_mgmt_exec), .net_mgmt_in(net_mgmt_in), .net_app_in(net_app_in),
        .net_mgmt_answer(net_mgmt_answer), .net_app_answer(net_app_answer), .net_tx(net_tx),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );
    hlsc_host_model u_host (
        .clk_sys(clk_sys), .rst(rst), .go(go), .go_cmd(go_cmd), .go_acked(go_acked),
        .auto_cancel(auto_cancel), .uplink_host_reset(uplink_host_reset), .host_req(host_req)
    );

    // Comparison and verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        check_count++;
        if (seen !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, seen);
        end
    endtask : chk
    task automatic end_sim;
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    // One register write or read; handshakes sampled 1 ns after each edge
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic aw, w, ar, done;
        int n;
        @(posedge clk_sys);
        if (wr)
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        end
        else
        begin
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'b11;
        end
        for (n = 0; n < 20; n++)
        begin
            #1;
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            ar = s_axi_arvalid && s_axi_arready;
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            resp = wr ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            @(posedge clk_sys);
            if (aw)
                s_axi_awvalid <= 1'b0;
            if (w)
                s_axi_wvalid <= 1'b0;
            if (ar)
                s_axi_arvalid <= 1'b0;
            if (done)
                break;
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        if (n == 20)
        begin
            failures++;
            end_sim();
        end
    endtask : axi
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        axi(1'b0, a, 32'h0);
        chk(nm, rd & m, e);
        chk("read resp", 32'(resp), 32'(hlsc_pkg::AXI_OKAY));
    endtask : rd_chk

    // Command through the host model; returns once its answer is settled
    task automatic cmd_go(input hlsc_pkg::hlsc_cmd_t c, input logic a);
        @(posedge clk_sys);
        go <= 1'b1;
        go_cmd <= c;
        go_acked <= a;
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : cmd_go
    task automatic send_chk(input logic a, input logic s, input logic t);
        cmd_go(hlsc_pkg::CMD_SEND, a);
        chk("send completion", 32'({send_cpl, net_tx}), 32'({1'b1, s, t, t}));
    endtask : send_chk
    task automatic net_chk(input logic m, input logic e);
        @(posedge clk_sys);
        net_mgmt_in <= m;
        net_app_in <= !m;
        @(posedge clk_sys);
        {net_mgmt_in, net_app_in} <= 2'b00;
        #1;
        chk("network answer", 32'(m ? net_mgmt_answer : net_app_answer), 32'(e));
    endtask : net_chk
    task automatic do_reset(input logic p, input logic s);
        @(posedge clk_sys);
        rst <= 1'b1;
        por <= p;
        net_enable_switch <= s;
        repeat (10) @(posedge clk_sys);
        {rst, por} <= 2'b00;
        @(posedge clk_sys);
        #1;
        chk("uplink after reset", 32'(uplink_host_reset), 32'h1);
    endtask : do_reset

    // Scenarios
    task automatic t_held;
        do_reset(1'b1, 1'b0);
        rd_chk("status held", hlsc_pkg::REG_STATUS, HM | CM, HM);
        send_chk(1'b1, 1'b0, 1'b0);
        rd_chk("result fail", hlsc_pkg::REG_RESULT, 32'h1, 32'h0);
        send_chk(1'b0, 1'b1, 1'b0);
        net_chk(1'b1, 1'b0);
        cmd_go(hlsc_pkg::CMD_LOCAL_MGMT, 1'b0);
        chk("local mgmt", 32'(local_mgmt_exec), 32'h1);
    endtask : t_held
    task automatic t_unconf;
        cmd_go(hlsc_pkg::CMD_HOLDOFF_CANCEL, 1'b0);
        rd_chk("cancelled", hlsc_pkg::REG_STATUS, HM | CM, 32'h0);
        send_chk(1'b1, 1'b1, 1'b0);
        send_chk(1'b0, 1'b1, 1'b0);
        net_chk(1'b1, 1'b1);
        net_chk(1'b0, 1'b0);
    endtask : t_unconf
    task automatic t_config;
        axi(1'b1, hlsc_pkg::REG_CTRL, 32'h0000_0001);
        rd_chk("no domain", hlsc_pkg::REG_STATUS, CM, 32'h0);
        axi(1'b1, hlsc_pkg::REG_DOMAIN1, 32'h0000_0005);
        chk("write resp", 32'(resp), 32'(hlsc_pkg::AXI_OKAY));
        axi(1'b1, hlsc_pkg::REG_CTRL, 32'h0000_0001);
        rd_chk("configured", hlsc_pkg::REG_STATUS, CM, CM);
        axi(1'b1, hlsc_pkg::REG_CTRL, 32'h0000_0002);
        rd_chk("unconfigured", hlsc_pkg::REG_STATUS, 32'hE, 32'h0);
        axi(1'b1, hlsc_pkg::REG_DOMAIN0, 32'h0000_0003);
        axi(1'b1, hlsc_pkg::REG_CTRL, 32'h0000_0001);
        rd_chk("reconfigured", hlsc_pkg::REG_STATUS, 32'hE, 32'h6);
        rd_chk("domain0", hlsc_pkg::REG_DOMAIN0, '1, 32'h3);
        send_chk(1'b1, 1'b1, 1'b1);
        net_chk(1'b0, 1'b1);
    endtask : t_config
    task automatic t_params;
        axi(1'b1, hlsc_pkg::REG_CLKRATE, 32'h0098_967F);
        rd_chk("clk kept", hlsc_pkg::REG_CLKRATE, '1, hlsc_pkg::CLKRATE_HZ);
        rd_chk("clk flag", hlsc_pkg::REG_STATUS, 32'h1 << hlsc_pkg::ST_CLK_REJ,
            32'h1 << hlsc_pkg::ST_CLK_REJ);
        axi(1'b1, hlsc_pkg::REG_CHANNEL, {24'h0, XCVR + 8'h01});
        rd_chk("chan kept", hlsc_pkg::REG_CHANNEL, 32'hFF, 32'h0);
        rd_chk("chan flag", hlsc_pkg::REG_STATUS, 32'h1 << hlsc_pkg::ST_CHAN_REJ,
            32'h1 << hlsc_pkg::ST_CHAN_REJ);
        axi(1'b1, hlsc_pkg::REG_CHANNEL, {24'h0, XCVR});
        rd_chk("chan new", hlsc_pkg::REG_CHANNEL, 32'hFF, {24'h0, XCVR});
        axi(1'b0, 8'h20, 32'h0);
        chk("unmapped resp", 32'(resp), 32'(hlsc_pkg::AXI_SLVERR));
        chk("unmapped data", rd, 32'h0);
        axi(1'b1, 8'h20, 32'h0);
        chk("unmapped wr resp", 32'(resp), 32'(hlsc_pkg::AXI_SLVERR));
        rd_chk("xcvr id", hlsc_pkg::REG_XCVR, '1, {24'h0, XCVR});
        @(posedge clk_sys);
        s_axi_wstrb <= 4'h1;
        axi(1'b1, hlsc_pkg::REG_DOMAIN1, 32'h0000_0009);
        s_axi_wstrb <= 4'hF;
        rd_chk("partial ignored", hlsc_pkg::REG_DOMAIN1, '1, 32'h5);
    endtask : t_params
    task automatic t_persist;
        do_reset(1'b0, 1'b1);
        rd_chk("kept config", hlsc_pkg::REG_STATUS, HM | CM, CM);
        rd_chk("switch bit", hlsc_pkg::REG_STATUS, 32'h1 << hlsc_pkg::ST_SW,
            32'h1 << hlsc_pkg::ST_SW);
        @(posedge clk_sys);
        net_enable_switch <= 1'b0;
        auto_cancel <= 1'b1;
        cmd_go(hlsc_pkg::CMD_HOST_RESET, 1'b0);
        @(posedge clk_sys);
        #1;
        chk("uplink after command", 32'(uplink_host_reset), 32'h1);
        repeat (3) @(posedge clk_sys);
        rd_chk("auto cancel", hlsc_pkg::REG_STATUS, HM | CM, CM);
        do_reset(1'b1, 1'b0);
        rd_chk("power wipe", hlsc_pkg::REG_STATUS, CM, 32'h0);
    endtask : t_persist

    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Main sequence
    initial
    begin
        {rst, por, net_enable_switch, go, go_acked, auto_cancel} = 6'b110000;
        {net_mgmt_in, net_app_in, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        go_cmd = hlsc_pkg::CMD_NONE;
        t_held();
        t_unconf();
        t_config();
        t_params();
        t_persist();
        end_sim();
    end
endmodule : hlsc_tb_top

bind hlsc_top hlsc_chk u_chk (
    .clk_sys(clk_sys), .rst(rst), .net_enable_switch(net_enable_switch),
    .host_req(host_req), .send_cpl(send_cpl), .uplink_host_reset(uplink_host_reset),
    .local_mgmt_exec(local_mgmt_exec), .net_mgmt_in(net_mgmt_in),
    .net_mgmt_answer(net_mgmt_answer), .net_tx(net_tx)
);
